// file: hdl/dfr_regs.sv
// Function
// - Alarm byte 112 holds high/low alarms for temp, supply, bias, tx power.
// - Alarm byte 113 holds rx power high alarm bit 7, low bit 6, rest reserved.
// - Warning byte 116 mirrors byte 112 using the warning thresholds.
// - Warning byte 117 holds rx power high bit 7, low bit 6, rest reserved.
// - Software transmit-disable bit 6 ORed with the transmit-disable pin.
// - Software control commands take effect within 100 ms of the write.
// - Byte 118 bit 3 is read/write transmit rate; one selects full speed.
// - Byte 118 bit 1 always reads zero, high power class not active.
// - Receive and transmit rate pin levels read in byte 110 bits 4 and 5.
// - Software receive and transmit rate bits are zero after power-on.
// - Each direction runs 1.25G only when pin and software bit are zero.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
`include "dfr_params.svh"

module dfr_regs
   import dfr_pkg::*;
#(
   parameter int unsigned SOFT_RESP_CYC = `DFR_SOFT_RESP_CYC
) (
   // Clock and reset.
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave.
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Threshold comparison results, same clock domain.
   input wire logic meas_update,
   input wire logic [4:0] alm_hi_cmp,
   input wire logic [4:0] alm_lo_cmp,
   input wire logic [4:0] wrn_hi_cmp,
   input wire logic [4:0] wrn_lo_cmp,
   // Module pins, asynchronous.
   input wire logic tx_disable_pin,
   input wire logic rx_rate_pin,
   input wire logic tx_rate_pin,
   input wire logic tx_fault_pin,
   input wire logic rx_los_pin,
   // Controls to the optics.
   output logic tx_disable_out,
   output logic rx_full_rate,
   output logic tx_full_rate
);

   // Pin synchronisers: stage one feeds only stage two.
   logic [4:0] pin_s1_q;
   logic [4:0] pin_s2_q;
   wire logic [4:0] pins_raw = {tx_disable_pin, rx_rate_pin, tx_rate_pin, tx_fault_pin,
      rx_los_pin};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_s1_q <= 5'h00;
         pin_s2_q <= 5'h00;
      end else begin
         pin_s1_q <= pins_raw;
         pin_s2_q <= pin_s1_q;
      end
   end

   wire logic txdis_s = pin_s2_q[4];
   wire logic rx_rate_s = pin_s2_q[3];
   wire logic tx_rate_s = pin_s2_q[2];
   wire logic tx_fault_s = pin_s2_q[1];
   wire logic rx_los_s = pin_s2_q[0];

   // Address phase decode.
   wire logic addr_take = hsel && htrans[1] && hready;
   wire logic addr_ok = (haddr[31:10] == 22'h000000);
   wire logic [7:0] addr_idx = haddr[9:2];
   wire dfr_sel_t addr_sel =
      !addr_ok ? DFR_SEL_NONE :
      (addr_idx == `DFR_IDX_STATUS) ? DFR_SEL_STATUS :
      (addr_idx == `DFR_IDX_ALM_HI) ? DFR_SEL_ALM_HI :
      (addr_idx == `DFR_IDX_ALM_LO) ? DFR_SEL_ALM_LO :
      (addr_idx == `DFR_IDX_WRN_HI) ? DFR_SEL_WRN_HI :
      (addr_idx == `DFR_IDX_WRN_LO) ? DFR_SEL_WRN_LO :
      (addr_idx == `DFR_IDX_EXT_CTL) ? DFR_SEL_EXT_CTL : DFR_SEL_NONE;

   // Data phase state captured from the address phase.
   logic wr_pend_q;
   dfr_sel_t wr_sel_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_sel_q <= DFR_SEL_NONE;
      end else begin
         wr_pend_q <= addr_take && hwrite;
         wr_sel_q <= addr_sel;
      end
   end

   wire logic wr_status = wr_pend_q && (wr_sel_q == DFR_SEL_STATUS);
   wire logic wr_ext = wr_pend_q && (wr_sel_q == DFR_SEL_EXT_CTL);

   // Software control bits; a write lands at the end of its data phase.
   logic sw_txdis_q;
   logic sw_txdis_d;
   logic sw_rx_rate_q;
   logic sw_rx_rate_d;
   logic sw_tx_rate_q;
   logic sw_tx_rate_d;
   logic pwr_sel_q;
   logic pwr_sel_d;
   logic data_nrdy_q;

   assign sw_txdis_d = wr_status ? hwdata[`DFR_ST_SW_TXDIS] : sw_txdis_q;
   assign sw_rx_rate_d = wr_status ? hwdata[`DFR_ST_SW_RX_RATE] : sw_rx_rate_q;
   assign sw_tx_rate_d = wr_ext ? hwdata[`DFR_EC_SW_TX_RATE] : sw_tx_rate_q;
   // Power class select is kept for read-back only and steers nothing.
   assign pwr_sel_d = wr_ext ? hwdata[`DFR_EC_PWR_SEL] : pwr_sel_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_txdis_q <= `DFR_RST_BIT;
         sw_rx_rate_q <= `DFR_RST_BIT;
         sw_tx_rate_q <= `DFR_RST_BIT;
         pwr_sel_q <= `DFR_RST_BIT;
         data_nrdy_q <= 1'b1;
      end else begin
         sw_txdis_q <= sw_txdis_d;
         sw_rx_rate_q <= sw_rx_rate_d;
         sw_tx_rate_q <= sw_tx_rate_d;
         pwr_sel_q <= pwr_sel_d;
         if (meas_update) begin
            data_nrdy_q <= 1'b0;
         end
      end
   end

   // Controls act in the cycle after the write, well inside the response time.
   assign tx_disable_out = txdis_s | sw_txdis_q;
   assign rx_full_rate = rx_rate_s | sw_rx_rate_q;
   assign tx_full_rate = tx_rate_s | sw_tx_rate_q;

   // Alarm and warning flags follow each comparison result.
   dfr_meas_t alm_hi_q;
   dfr_meas_t alm_lo_q;
   dfr_meas_t wrn_hi_q;
   dfr_meas_t wrn_lo_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         alm_hi_q <= 5'h00;
         alm_lo_q <= 5'h00;
         wrn_hi_q <= 5'h00;
         wrn_lo_q <= 5'h00;
      end else if (meas_update) begin
         alm_hi_q <= alm_hi_cmp;
         alm_lo_q <= alm_lo_cmp;
         wrn_hi_q <= wrn_hi_cmp;
         wrn_lo_q <= wrn_lo_cmp;
      end
   end

   // Pack high/low pairs, temperature in the top bits.
   logic [9:0] alm_w;
   logic [9:0] wrn_w;
   for (genvar m = 0; m < `DFR_NUM_MEAS; m++) begin : g_pack
      assign alm_w[9 - 2 * m] = alm_hi_q[m];
      assign alm_w[8 - 2 * m] = alm_lo_q[m];
      assign wrn_w[9 - 2 * m] = wrn_hi_q[m];
      assign wrn_w[8 - 2 * m] = wrn_lo_q[m];
   end

   wire dfr_byte_t alm_hi_byte = alm_w[9:2];
   wire dfr_byte_t alm_lo_byte = {alm_w[1:0], 6'h00};
   wire dfr_byte_t wrn_hi_byte = wrn_w[9:2];
   wire dfr_byte_t wrn_lo_byte = {wrn_w[1:0], 6'h00};

   // Read views use next values so a read right after a write sees it.
   wire dfr_byte_t status_byte = {txdis_s, sw_txdis_d, tx_rate_s, rx_rate_s,
      sw_rx_rate_d, tx_fault_s, rx_los_s, data_nrdy_q};
   wire dfr_byte_t ext_byte = {4'h0, sw_tx_rate_d, 1'b0, 1'b0, pwr_sel_d};

   wire dfr_byte_t rd_byte =
      (addr_sel == DFR_SEL_STATUS) ? status_byte :
      (addr_sel == DFR_SEL_ALM_HI) ? alm_hi_byte :
      (addr_sel == DFR_SEL_ALM_LO) ? alm_lo_byte :
      (addr_sel == DFR_SEL_WRN_HI) ? wrn_hi_byte :
      (addr_sel == DFR_SEL_WRN_LO) ? wrn_lo_byte :
      (addr_sel == DFR_SEL_EXT_CTL) ? ext_byte : 8'h00;

   logic [31:0] hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (addr_take && !hwrite) begin
         hrdata_q <= {24'h000000, rd_byte};
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // Checks.
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence seq_wr_status_txdis;
      addr_take && hwrite && (addr_sel == DFR_SEL_STATUS) ##1 hwdata[`DFR_ST_SW_TXDIS];
   endsequence

   sequence seq_wr_ext_txrate;
      addr_take && hwrite && (addr_sel == DFR_SEL_EXT_CTL) ##1 hwdata[`DFR_EC_SW_TX_RATE];
   endsequence

   sequence seq_rd_ext;
      addr_take && !hwrite && (addr_sel == DFR_SEL_EXT_CTL);
   endsequence

   wire logic rd_ext_take = addr_take && !hwrite && (addr_sel == DFR_SEL_EXT_CTL);

   // Counts cycles from a status write until the disable output is set; a write clearing the bit stops it one cycle later.
   logic [31:0] resp_cnt_q;
   logic resp_pend_q;
   logic resp_want_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         resp_pend_q <= 1'b0;
         resp_want_q <= 1'b0;
         resp_cnt_q <= 32'h00000000;
      end else if (wr_status) begin
         resp_pend_q <= 1'b1;
         resp_want_q <= hwdata[`DFR_ST_SW_TXDIS];
         resp_cnt_q <= 32'h00000000;
      end else if (resp_pend_q) begin
         if (!resp_want_q || tx_disable_out) begin
            resp_pend_q <= 1'b0;
         end
         resp_cnt_q <= resp_cnt_q + 32'h00000001;
      end
   end

   AST_ALM_HI: assert property (
      meas_update |=> alm_hi_byte == {$past(alm_hi_cmp[0]), $past(alm_lo_cmp[0]),
         $past(alm_hi_cmp[1]), $past(alm_lo_cmp[1]), $past(alm_hi_cmp[2]),
         $past(alm_lo_cmp[2]), $past(alm_hi_cmp[3]), $past(alm_lo_cmp[3])})
      else $error("alarm byte does not match the comparisons");

   AST_ALM_LO: assert property (
      meas_update |=> alm_lo_byte == {$past(alm_hi_cmp[4]), $past(alm_lo_cmp[4]), 6'h00})
      else $error("rx alarm byte does not match the comparisons");

   AST_WRN_HI: assert property (
      meas_update |=> wrn_hi_byte == {$past(wrn_hi_cmp[0]), $past(wrn_lo_cmp[0]),
         $past(wrn_hi_cmp[1]), $past(wrn_lo_cmp[1]), $past(wrn_hi_cmp[2]),
         $past(wrn_lo_cmp[2]), $past(wrn_hi_cmp[3]), $past(wrn_lo_cmp[3])})
      else $error("warning byte does not match the comparisons");

   AST_WRN_LO: assert property (
      meas_update |=> wrn_lo_byte == {$past(wrn_hi_cmp[4]), $past(wrn_lo_cmp[4]), 6'h00})
      else $error("rx warning byte does not match the comparisons");

   AST_TXDIS_SW: assert property (
      seq_wr_status_txdis |=> tx_disable_out)
      else $error("software disable did not shut the transmitter");

   AST_TXDIS_PIN: assert property (
      tx_disable_pin [*3] |-> tx_disable_out)
      else $error("disable pin did not shut the transmitter");

   AST_SOFT_RESP: assert property (
      resp_pend_q |-> resp_cnt_q < SOFT_RESP_CYC)
      else $error("soft command took too long to act");

   AST_TXRATE_WR: assert property (
      seq_wr_ext_txrate |=> tx_full_rate ##1
         (hrdata[`DFR_EC_SW_TX_RATE] || !$past(rd_ext_take)))
      else $error("transmit rate write not taken");

   AST_HP_CLASS: assert property (
      seq_rd_ext |=> !hrdata[`DFR_EC_HP_CLASS])
      else $error("high power class bit read as one");

   AST_PIN_STATUS: assert property (
      (rx_rate_pin && tx_rate_pin) [*3] |-> status_byte[5:4] == 2'b11)
      else $error("rate pin levels not shown in status");

   AST_RESET_SW: assert property (@(posedge hclk) disable iff (1'b0)
      $rose(hresetn) |-> !sw_rx_rate_q && !sw_tx_rate_q)
      else $error("software rate bits not zero after reset");

   AST_RATE_LOW: assert property (
      (!tx_rate_pin && !sw_tx_rate_q) [*3] |-> !tx_full_rate)
      else $error("transmit not at low rate with pin and bit clear");

   AST_RATE_RX: assert property (
      $rose(sw_rx_rate_q) |-> rx_full_rate)
      else $error("receive rate bit did not select full rate");

   AST_FLAG_HOLD: assert property (
      !meas_update |=> $stable(alm_hi_q) && $stable(wrn_lo_q))
      else $error("flags changed without a comparison");

endmodule // dfr_regs

`default_nettype wire

// file: hdl/dfr_params.svh
`ifndef DFR_PARAMS_SVH
`define DFR_PARAMS_SVH

// Register indices; the byte address is four times the index.
`define DFR_IDX_STATUS 8'h6e
`define DFR_IDX_ALM_HI 8'h70
`define DFR_IDX_ALM_LO 8'h71
`define DFR_IDX_WRN_HI 8'h74
`define DFR_IDX_WRN_LO 8'h75
`define DFR_IDX_EXT_CTL 8'h76

// Status/control byte field positions.
`define DFR_ST_TXDIS_PIN 7
`define DFR_ST_SW_TXDIS 6
`define DFR_ST_TX_RATE_PIN 5
`define DFR_ST_RX_RATE_PIN 4
`define DFR_ST_SW_RX_RATE 3
`define DFR_ST_TX_FAULT 2
`define DFR_ST_RX_LOS 1
`define DFR_ST_DATA_NRDY 0

// Extended control byte field positions.
`define DFR_EC_SW_TX_RATE 3
`define DFR_EC_HP_CLASS 1
`define DFR_EC_PWR_SEL 0

// Reset values of the writable bits.
`define DFR_RST_BIT 1'b0
`define DFR_RST_BYTE 8'h00

// Soft command response time and clock rate.
`define DFR_SOFT_RESP_MS 100
`define DFR_CLK_MHZ 100
`define DFR_SOFT_RESP_CYC (`DFR_SOFT_RESP_MS * `DFR_CLK_MHZ * 1000)

// Number of monitored quantities: temperature, supply, bias, tx power, rx power.
`define DFR_NUM_MEAS 5

`endif

// file: hdl/dfr_pkg.sv
package dfr_pkg;

   typedef logic [7:0] dfr_byte_t;

   typedef logic [4:0] dfr_meas_t;

   typedef enum logic [2:0] {
      DFR_SEL_NONE = 3'h0,
      DFR_SEL_STATUS = 3'h1,
      DFR_SEL_ALM_HI = 3'h3,
      DFR_SEL_ALM_LO = 3'h2,
      DFR_SEL_WRN_HI = 3'h6,
      DFR_SEL_WRN_LO = 3'h7,
      DFR_SEL_EXT_CTL = 3'h5
   } dfr_sel_t;

endpackage

// file: tb/dfr_host.sv
`timescale 1ns/1ns
`default_nettype none

module dfr_host (
   // Clock.
   input wire logic hclk,
   // Master request.
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   // Slave answer.
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // One single word transfer; the write data is inverted once released.
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {22'h0, idx, 2'b00};
      htrans <= 2'h2;
      hwrite <= wr;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      rd = hrdata;
      hwdata <= ~wd;
   endtask
endmodule // dfr_host

`default_nettype wire

// file: tb/diag_flags_rate_select_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "dfr_params.svh"

`define CHK(got, exp) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         error_cnt++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
      end \
   end

module diag_flags_rate_select_test;
   import dfr_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, meas_update;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [4:0] alm_hi_cmp, alm_lo_cmp, wrn_hi_cmp, wrn_lo_cmp;
   logic tx_disable_pin, rx_rate_pin, tx_rate_pin, tx_fault_pin, rx_los_pin;
   logic tx_disable_out, rx_full_rate, tx_full_rate;
   int error_cnt = 0;
   int n_tests = 0;

   dfr_host host (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata));

   dfr_regs #(.SOFT_RESP_CYC(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .meas_update(meas_update), .alm_hi_cmp(alm_hi_cmp), .alm_lo_cmp(alm_lo_cmp),
      .wrn_hi_cmp(wrn_hi_cmp), .wrn_lo_cmp(wrn_lo_cmp), .tx_disable_pin(tx_disable_pin),
      .rx_rate_pin(rx_rate_pin), .tx_rate_pin(tx_rate_pin), .tx_fault_pin(tx_fault_pin),
      .rx_los_pin(rx_los_pin), .tx_disable_out(tx_disable_out),
      .rx_full_rate(rx_full_rate), .tx_full_rate(tx_full_rate));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   function automatic dfr_byte_t flg(input logic [4:0] h, input logic [4:0] l);
      return {h[0], l[0], h[1], l[1], h[2], l[2], h[3], l[3]};
   endfunction

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] unused;
      host.xfer(1'b1, idx, {24'h0, d}, unused);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] v);
      host.xfer(1'b0, idx, 32'h0, v);
   endtask

   task automatic chk_rd(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] v;
      rd(idx, v);
      `CHK(v, exp)
   endtask

   // Loads one set of comparison results and reads back all four flag bytes.
   task automatic meas(input logic [4:0] ah, al, wh, wl);
      @(posedge hclk);
      alm_hi_cmp <= ah;
      alm_lo_cmp <= al;
      wrn_hi_cmp <= wh;
      wrn_lo_cmp <= wl;
      meas_update <= 1'b1;
      @(posedge hclk);
      meas_update <= 1'b0;
      chk_rd(`DFR_IDX_ALM_HI, {24'h0, flg(ah, al)});
      chk_rd(`DFR_IDX_ALM_LO, {24'h0, ah[4], al[4], 6'h0});
      chk_rd(`DFR_IDX_WRN_HI, {24'h0, flg(wh, wl)});
      chk_rd(`DFR_IDX_WRN_LO, {24'h0, wh[4], wl[4], 6'h0});
   endtask

   task automatic conclude();
      $display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #50000;
      error_cnt++;
      conclude();
   end

   initial begin
      logic [31:0] v;
      int i;
      hresetn = 1'b0;
      meas_update = 1'b0;
      {alm_hi_cmp, alm_lo_cmp, wrn_hi_cmp, wrn_lo_cmp} = 20'h0;
      {tx_disable_pin, rx_rate_pin, tx_rate_pin, tx_fault_pin, rx_los_pin} = 5'h0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      chk_rd(`DFR_IDX_STATUS, 32'h01);
      chk_rd(`DFR_IDX_EXT_CTL, 32'h00);
      `CHK({hreadyout, hresp, rx_full_rate, tx_full_rate, tx_disable_out}, 5'h10)
      $display("test reset done");
      wr(`DFR_IDX_EXT_CTL, 8'hff);
      chk_rd(`DFR_IDX_EXT_CTL, 32'h09);
      `CHK(tx_full_rate, 1'b1)
      wr(`DFR_IDX_EXT_CTL, 8'h00);
      chk_rd(`DFR_IDX_EXT_CTL, 32'h00);
      $display("test ext control done");
      // Every pin and soft bit combination for both directions.
      for (i = 0; i < 16; i++) begin
         rx_rate_pin <= i[3];
         tx_rate_pin <= i[1];
         wr(`DFR_IDX_STATUS, {4'h0, i[2], 3'h0});
         wr(`DFR_IDX_EXT_CTL, {4'h0, i[0], 3'h0});
         repeat (3) @(posedge hclk);
         `CHK(rx_full_rate, i[3] | i[2])
         `CHK(tx_full_rate, i[1] | i[0])
         rd(`DFR_IDX_STATUS, v);
         `CHK(v[5:3], {i[1], i[3], i[2]})
      end
      $display("test rate select done");
      for (i = 0; i < 4; i++) begin
         tx_disable_pin <= i[1];
         tx_fault_pin <= i[1];
         rx_los_pin <= i[0];
         wr(`DFR_IDX_STATUS, {1'b0, i[0], 6'h0});
         repeat (3) @(posedge hclk);
         `CHK(tx_disable_out, i[1] | i[0])
         rd(`DFR_IDX_STATUS, v);
         `CHK({v[7:6], v[2:1]}, {i[1], i[0], i[1], i[0]})
      end
      $display("test transmit disable done");
      for (i = 0; i < 5; i++) begin
         meas(5'h01 << i, ~(5'h01 << i), 5'h1f >> i, 5'h15 ^ (5'h01 << i));
      end
      meas(5'h0, 5'h0, 5'h0, 5'h0);
      rd(`DFR_IDX_STATUS, v);
      `CHK(v[0], 1'b0)
      wr(`DFR_IDX_ALM_HI, 8'hff);
      chk_rd(`DFR_IDX_ALM_HI, 32'h00);
      wr(8'h72, 8'hff);
      chk_rd(8'h72, 32'h00);
      $display("test flags done");
      conclude();
   end
endmodule // diag_flags_rate_select_test

`default_nettype wire
